// File: rtl/link_cfg.svh
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH
// Register word indices (byte address bits 5:2)
`define REG_CONTROL 4'h0
`define REG_LINK 4'h1
`define REG_IDENT 4'h2
`define REG_STATUS 4'h3
// Control word fields
`define CTL_LINK_EN 0
`define CTL_PAR_DIS 1
`define CTL_SCR_EN 2
`define CTL_MODE 4:3
`define CTL_VER_OVR 5
`define CTL_VER 10:8
`define CTL_SUB 14:12
`define CTL_RESET 32'h0000_1100
// Link configuration word fields
`define LNK_CPL 1:0
`define LNK_RES 3:2
`define LNK_SER 5:4
`define LNK_SINGLE 6
`define LNK_K_M1 12:8
`define LNK_RESET 32'h0000_0215
// Identity word fields
`define IDN_BANK 3:0
`define IDN_DEV 15:8
`define IDN_RESET 32'h0000_0000
// Input-count modes
`define MODE_16IN 2'h0
`define MODE_32IN 2'h1
`define MODE_8IN 2'h2
// Code choices
`define CPL_2 2'h0
`define CPL_4 2'h1
`define CPL_8 2'h2
`define RES_10 2'h0
`define RES_12 2'h1
`define RES_14 2'h2
// Version and subclass codes
`define VER_204A 3'h0
`define VER_204B 3'h1
`define SUB_0 3'h0
`define SUB_1 3'h1
`define SUB_2 3'h2
// Fixed link parameters
`define M_M1 8'h0f
`define S_M1 5'h00
`define SAMPLE_BITS 16
`define MAX_CPL 8
`define ILAS_LAST_MF 2'h3
`define ILAS_CFG_FIRST 9'h002
`define ILAS_CFG_END 9'h010
`define ILAS_Q_POS 9'h001
// Control characters and scrambler seed
`define K_R 8'h1c
`define K_A 8'h7c
`define K_Q 8'h9c
`define K_K 8'hbc
`define K_F 8'hfc
`define SCR_SEED 15'h7f80
// Lane rate limit
`define CLK_MHZ 125
`define BITS_PER_SYMBOL 10
`define LANE_MAX_MBPS 5000
`endif

// File: rtl/link_pkg.sv
package link_pkg;
	typedef logic [15:0] sample_type;
	typedef struct packed {
		sample_type [15:0] word;
	} sample_frame_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CGS = 2'b01,
		ST_ILAS = 2'b10,
		ST_DATA = 2'b11
	} link_state_type;
	typedef struct packed {
		logic [7:0] did;
		logic [3:0] bid;
		logic scr;
		logic [4:0] l_m1;
		logic [7:0] f_m1;
		logic [4:0] k_m1;
		logic [4:0] n_m1;
		logic [4:0] np_m1;
		logic [2:0] subv;
		logic [2:0] jesdv;
	} link_cfg_type;
endpackage

// File: rtl/lane_tx.sv
`timescale 1ns/1ps
`include "link_cfg.svh"
module lane_tx
	import link_pkg::*;
#(
	parameter logic [4:0] LANE_ID = 5'h00
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire link_state_type state_in,
	input wire logic [8:0] pos_in,
	input wire logic [1:0] ilas_mf_in,
	input wire logic frame_end_in,
	input wire logic mf_end_in,
	input wire logic scramble_in,
	input wire link_cfg_type cfg_in,
	input wire logic [7:0] octet_in,
	output logic [9:0] symbol_out
);
	// Encoding tables, first-sent bit highest
	localparam logic [5:0] TBL6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
		6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [3:0] TBL4D [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
	localparam logic [3:0] TBL4K [8] = '{4'hb, 4'h6, 4'ha, 4'hc, 4'hd, 4'h5, 4'h9, 4'h7};
	localparam logic [5:0] K28_6B = 6'h0f;
	logic [14:0] scr_state; // Scrambler history
	logic [7:0] prev_last; // Last octet of previous frame
	logic rd; // Running disparity, high is positive
	logic [7:0] cfg_octet [14]; // Lane configuration octets
	logic [7:0] chk; // Field checksum
	logic [7:0] tx_octet; // Octet chosen for encoding
	logic tx_k; // Control character marker
	logic [22:0] scr_res; // Scrambled octet and new history
	logic [10:0] enc; // New disparity and symbol
	// Self-synchronous 1 + x^14 + x^15, MSB first
	function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] s);
		logic [14:0] st;
		logic [7:0] o;
		st = s;
		o = 8'h00;
		for (int b = 7; b >= 0; b--) begin
			o[b] = d[b] ^ st[13] ^ st[14];
			st = {st[13:0], o[b]};
		end
		return {o, st};
	endfunction
	// 5b/6b then 3b/4b, only K28.y control codes
	function automatic logic [10:0] enc_8b10b(input logic [7:0] d, input logic k, input logic r);
		logic [5:0] c6;
		logic [3:0] c4;
		logic r6;
		logic [4:0] x;
		logic [2:0] y;
		x = d[4:0];
		y = d[7:5];
		c6 = k ? K28_6B : TBL6[x];
		// Unbalanced codes and D.7 flip at positive disparity
		if (r && (($countones(c6) != 3) || (!k && x == 5'h07))) begin
			c6 = ~c6;
		end
		r6 = r ^ ($countones(c6) != 3);
		c4 = k ? TBL4K[y] : TBL4D[y];
		// Alternate D.x.7 avoids a run of five
		if (!k && y == 3'h7 && ((!r6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
			(r6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)))) begin
			c4 = 4'h7;
		end
		if (r6 && (k || y == 3'h0 || y == 3'h3 || y == 3'h4 || y == 3'h7)) begin
			c4 = ~c4;
		end
		return {r6 ^ ($countones(c4) != 2), c6, c4};
	endfunction
	// Reserved octets go out as zero, M minus one is fixed at 0x0f; device and bank identifiers from software
	assign chk = cfg_in.did + {4'h0, cfg_in.bid} + {3'h0, LANE_ID} + {7'h00, cfg_in.scr} + {3'h0, cfg_in.l_m1}
		+ cfg_in.f_m1 + {3'h0, cfg_in.k_m1} + `M_M1 + {3'h0, cfg_in.n_m1} + {5'h00, cfg_in.subv}
		+ {3'h0, cfg_in.np_m1} + {5'h00, cfg_in.jesdv} + {3'h0, `S_M1};
	assign cfg_octet[0] = cfg_in.did;
	assign cfg_octet[1] = {4'h0, cfg_in.bid};
	assign cfg_octet[2] = {3'h0, LANE_ID};
	assign cfg_octet[3] = {cfg_in.scr, 2'h0, cfg_in.l_m1};
	assign cfg_octet[4] = cfg_in.f_m1; // Octets per frame minus one
	assign cfg_octet[5] = {3'h0, cfg_in.k_m1};
	assign cfg_octet[6] = `M_M1;
	assign cfg_octet[7] = {3'h0, cfg_in.n_m1};
	assign cfg_octet[8] = {cfg_in.subv, cfg_in.np_m1};
	assign cfg_octet[9] = {cfg_in.jesdv, `S_M1};
	assign cfg_octet[10] = 8'h00;
	assign cfg_octet[11] = 8'h00;
	assign cfg_octet[12] = 8'h00;
	assign cfg_octet[13] = chk;
	assign scr_res = scramble(octet_in, scr_state);
	// Octet and marker for each link phase
	always_comb begin
		tx_octet = `K_K;
		tx_k = 1'b1;
		case (state_in)
			ST_ILAS: begin
				// Alignment multiframes with start, end and config markers
				if (pos_in == 9'h000) begin
					tx_octet = `K_R;
				end else if (mf_end_in) begin
					tx_octet = `K_A;
				end else if (ilas_mf_in == 2'h1 && pos_in == `ILAS_Q_POS) begin
					tx_octet = `K_Q;
				end else if (ilas_mf_in == 2'h1 && pos_in >= `ILAS_CFG_FIRST && pos_in < `ILAS_CFG_END) begin
					tx_octet = cfg_octet[4'(pos_in - `ILAS_CFG_FIRST)];
					tx_k = 1'b0;
				end else begin
					tx_octet = pos_in[7:0];
					tx_k = 1'b0;
				end
			end
			ST_DATA: begin
				// Optional scrambling of data octets
				tx_octet = scramble_in ? scr_res[22:15] : octet_in;
				tx_k = 1'b0;
				// Boundary replacement lets the receiver watch alignment
				if (frame_end_in && (scramble_in ? (tx_octet == (mf_end_in ? `K_A : `K_F)) :
					(tx_octet == prev_last))) begin
					tx_octet = mf_end_in ? `K_A : `K_F;
					tx_k = 1'b1;
				end
			end
			default: begin
				// Comma stream for code group sync
				tx_octet = `K_K;
				tx_k = 1'b1;
			end
		endcase
	end
	assign enc = enc_8b10b(tx_octet, tx_k, rd);
	// Encoder register and scrambler history
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd <= 1'b0;
			symbol_out <= 10'h000;
			scr_state <= `SCR_SEED;
			prev_last <= 8'h00;
		end else begin
			rd <= enc[10]; // Each octet becomes one 10-bit symbol
			symbol_out <= enc[9:0];
			if (state_in == ST_DATA && scramble_in) begin
				scr_state <= scr_res[14:0];
			end else if (state_in != ST_DATA) begin
				scr_state <= `SCR_SEED;
			end
			if (state_in == ST_DATA && frame_end_in) begin
				prev_last <= scramble_in ? scr_res[22:15] : octet_in;
			end
		end
	end
endmodule

// File: rtl/serial_link_tx.sv
`timescale 1ns/1ps
`include "link_cfg.svh"
module serial_link_tx
	import link_pkg::*;
#(
	parameter int LANES = 8,
	parameter int OCTET_CLK_MHZ = `CLK_MHZ
) (
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic [5:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire sample_frame_type DATA_IN,
	input wire logic DATA_VALID_IN,
	input wire logic SYSREF_IN,
	input wire logic SYNC_N_IN,
	output sample_frame_type PARALLEL_DATA_OUT,
	output logic PARALLEL_VALID_OUT,
	output logic PARALLEL_ENABLE_OUT,
	output logic [LANES-1:0][9:0] LANE_SYMBOL_OUT,
	output logic [LANES-1:0] LANE_ENABLE_OUT
);
	localparam int FRAME_BITS = `MAX_CPL * `SAMPLE_BITS;
	// Rate check is static: one octet per clock, ten bits each
	localparam bit RATE_OK = (OCTET_CLK_MHZ * `BITS_PER_SYMBOL) <= `LANE_MAX_MBPS;

	// Software-visible registers
	logic [31:0] ctl; // Control word
	logic [31:0] lnk; // Link configuration word
	logic [31:0] idn; // Identity word
	logic waitreq; // Bus stall, low for one answer cycle
	// Link state and counters
	link_state_type state; // Link phase
	link_state_type next_state; // Phase for next cycle
	logic [3:0] oct_cnt; // Octet within frame
	logic [4:0] frm_cnt; // Frame within multiframe
	logic [8:0] pos_cnt; // Octet within multiframe
	logic [1:0] ilas_mf; // Alignment multiframe number
	logic sysref_q; // Previous sysref level
	logic sync_q; // Previous sync level
	sample_frame_type hold; // Latest input words

	// Bus decode
	wire [3:0] reg_idx = AVS_ADDRESS_IN[5:2];
	wire accept = (AVS_READ_IN | AVS_WRITE_IN) & waitreq; // New request seen
	wire commit = AVS_WRITE_IN & ~waitreq; // Edge where the write lands
	wire [31:0] wmask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
		{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
	wire [31:0] status_word;
	wire [31:0] rd_mux = (reg_idx == `REG_CONTROL) ? ctl :
		(reg_idx == `REG_LINK) ? lnk :
		(reg_idx == `REG_IDENT) ? idn :
		(reg_idx == `REG_STATUS) ? status_word : 32'h0000_0000;

	// Mode gating of the two output paths
	wire [1:0] mode = ctl[`CTL_MODE];
	wire mode_ok = (mode == `MODE_16IN) | (mode == `MODE_32IN); // No serial link in 8-input mode
	wire jesd_on = ctl[`CTL_LINK_EN] & mode_ok;
	wire lvds_on = ~(jesd_on & ctl[`CTL_PAR_DIS]);

	// Converters per lane; an unused code falls back to four
	wire [1:0] cpl_code = lnk[`LNK_CPL];
	wire [3:0] cpl = (cpl_code == `CPL_2) ? 4'h2 : (cpl_code == `CPL_8) ? 4'h8 : 4'h4;
	wire [3:0] lane_count = (cpl_code == `CPL_2) ? 4'h8 : (cpl_code == `CPL_8) ? 4'h2 : 4'h4;
	// Sample resolution in bits
	wire [1:0] res_code = lnk[`LNK_RES];
	wire [4:0] res = (res_code == `RES_10) ? 5'd10 : (res_code == `RES_12) ? 5'd12 :
		(res_code == `RES_14) ? 5'd14 : 5'd16;
	wire [1:0] ser_code = lnk[`LNK_SER];
	wire [4:0] ser = (ser_code == `RES_10) ? 5'd10 : (ser_code == `RES_12) ? 5'd12 :
		(ser_code == `RES_14) ? 5'd14 : 5'd16;
	// Bits per sample: packed at serialization width or one per octet pair
	wire [4:0] np = lnk[`LNK_SINGLE] ? 5'(`SAMPLE_BITS) : ser;
	wire [8:0] frame_bits = 9'(cpl * np);
	wire [8:0] f_oct = (frame_bits + 9'h007) >> 3; // Octets per frame, padded
	wire [7:0] f_m1 = 8'(f_oct - 9'h001);
	wire [4:0] k_m1 = lnk[`LNK_K_M1];
	wire cfg_err = (cpl_code == 2'h3) | (ser < res) | (mode == 2'h3);
	// Res mask keeps the top bits of each MSB-aligned word
	wire [15:0] res_mask = 16'hffff << (5'(`SAMPLE_BITS) - res);

	// Version and subclass choice
	wire ver_ovr = ctl[`CTL_VER_OVR];
	wire [2:0] jesdv = ver_ovr ? ctl[`CTL_VER] : `VER_204B;
	wire [2:0] subv = ver_ovr ? ctl[`CTL_SUB] : `SUB_1;
	wire [2:0] sub_eff = (jesdv == `VER_204A) ? `SUB_0 : subv;

	// Frame and multiframe boundaries
	wire frame_end = (oct_cnt == f_m1[3:0]);
	wire mf_end = frame_end & (frm_cnt == k_m1);
	// Local multiframe realigned by sysref or by sync release
	wire sysref_rise = SYSREF_IN & ~sysref_q;
	wire sync_rise = SYNC_N_IN & ~sync_q;
	wire realign = ((sub_eff == `SUB_1) & sysref_rise) | ((sub_eff == `SUB_2) & sync_rise & (state == ST_CGS));

	// Configuration handed to every lane
	link_cfg_type cfg;
	assign cfg.did = idn[`IDN_DEV];
	assign cfg.bid = idn[`IDN_BANK];
	assign cfg.scr = ctl[`CTL_SCR_EN];
	assign cfg.l_m1 = {1'b0, lane_count - 4'h1};
	assign cfg.f_m1 = f_m1;
	assign cfg.k_m1 = k_m1;
	assign cfg.n_m1 = res - 5'h01;
	assign cfg.np_m1 = np - 5'h01;
	assign cfg.subv = subv;
	assign cfg.jesdv = jesdv;

	assign status_word = {20'h00000, lane_count, 2'h0, RATE_OK, cfg_err, lvds_on, jesd_on, state};

	// Bus answer: one stall-free cycle per request
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			waitreq <= 1'b1;
			AVS_READDATA_OUT <= 32'h0000_0000;
		end else begin
			waitreq <= ~accept;
			if (accept) begin
				AVS_READDATA_OUT <= rd_mux;
			end
		end
	end
	assign AVS_WAITREQUEST_OUT = waitreq;

	// Register writes with byte lanes; status is read-only
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctl <= `CTL_RESET;
			lnk <= `LNK_RESET;
			idn <= `IDN_RESET;
		end else if (commit) begin
			if (reg_idx == `REG_CONTROL) begin
				ctl <= (ctl & ~wmask) | (AVS_WRITEDATA_IN & wmask);
			end
			if (reg_idx == `REG_LINK) begin
				lnk <= (lnk & ~wmask) | (AVS_WRITEDATA_IN & wmask);
			end
			if (reg_idx == `REG_IDENT) begin
				idn <= (idn & ~wmask) | (AVS_WRITEDATA_IN & wmask);
			end
		end
	end

	// Edge history for sysref and sync
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sysref_q <= 1'b0;
			sync_q <= 1'b1;
		end else begin
			sysref_q <= SYSREF_IN;
			sync_q <= SYNC_N_IN;
		end
	end

	// Octet, frame and multiframe counters
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			oct_cnt <= 4'h0;
			frm_cnt <= 5'h00;
			pos_cnt <= 9'h000;
		end else if (realign) begin
			oct_cnt <= 4'h0;
			frm_cnt <= 5'h00;
			pos_cnt <= 9'h000;
		end else if (mf_end) begin
			oct_cnt <= 4'h0;
			frm_cnt <= 5'h00;
			pos_cnt <= 9'h000;
		end else if (frame_end) begin
			oct_cnt <= 4'h0;
			frm_cnt <= frm_cnt + 5'h01;
			pos_cnt <= pos_cnt + 9'h001;
		end else begin
			oct_cnt <= oct_cnt + 4'h1;
			pos_cnt <= pos_cnt + 9'h001;
		end
	end

	// Link phase sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (jesd_on) begin
					next_state = ST_CGS;
				end
			end
			ST_CGS: begin
				// Leave the comma phase on a multiframe edge once sync releases
				if (SYNC_N_IN && mf_end && !realign) begin
					next_state = ST_ILAS;
				end
			end
			ST_ILAS: begin
				if (!SYNC_N_IN) begin
					next_state = ST_CGS;
				end else if (mf_end && ilas_mf == `ILAS_LAST_MF) begin
					next_state = ST_DATA;
				end
			end
			ST_DATA: begin
				// Receiver pulling sync low asks for a fresh sync
				if (!SYNC_N_IN) begin
					next_state = ST_CGS;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (!jesd_on) begin
			next_state = ST_IDLE;
		end
	end

	// Phase and alignment multiframe count
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state <= ST_IDLE;
			ilas_mf <= 2'h0;
		end else begin
			state <= next_state;
			if (state != ST_ILAS) begin
				ilas_mf <= 2'h0;
			end else if (mf_end) begin
				ilas_mf <= ilas_mf + 2'h1;
			end
		end
	end

	// Input capture and parallel path; the lanes get the same words masked to res bits
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			hold <= '0;
			PARALLEL_DATA_OUT <= '0;
			PARALLEL_VALID_OUT <= 1'b0;
			PARALLEL_ENABLE_OUT <= 1'b1;
		end else begin
			if (DATA_VALID_IN) begin
				hold <= DATA_IN;
				PARALLEL_DATA_OUT <= DATA_IN;
			end
			PARALLEL_VALID_OUT <= DATA_VALID_IN & lvds_on;
			PARALLEL_ENABLE_OUT <= lvds_on;
		end
	end

	// One packer, frame register and encoder per lane
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : lane
			logic [FRAME_BITS-1:0] packed_bits; // Frame built from this lane's words
			logic [FRAME_BITS-1:0] frame_reg; // Frame being sent
			logic [7:0] octet; // Current octet of the frame
			// Converter words packed MSB first at np bits each
			always_comb begin
				packed_bits = '0;
				for (int k = 0; k < `MAX_CPL; k++) begin
					if (k < int'(cpl) && (g * int'(cpl) + k) < `SAMPLE_BITS) begin
						packed_bits = packed_bits | ({hold.word[4'(g * int'(cpl) + k)] & res_mask,
							{(FRAME_BITS - `SAMPLE_BITS){1'b0}}} >> (k * int'(np)));
					end
				end
			end
			// New frame taken once per frame period
			always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN) begin
					frame_reg <= '0;
					LANE_ENABLE_OUT[g] <= 1'b0;
				end else begin
					if (frame_end) begin
						frame_reg <= packed_bits;
					end
					LANE_ENABLE_OUT[g] <= jesd_on & (4'(g) < lane_count) & (state != ST_IDLE);
				end
			end
			assign octet = frame_reg[{4'hf - oct_cnt, 3'h0} +: 8];
			lane_tx #(
				.LANE_ID(5'(g))
			) u_lane (
				.clk_in(MCLK_IN),
				.rst_n_in(RST_N_IN),
				.state_in(state),
				.pos_in(pos_cnt),
				.ilas_mf_in(ilas_mf),
				.frame_end_in(frame_end),
				.mf_end_in(mf_end),
				.scramble_in(ctl[`CTL_SCR_EN]),
				.cfg_in(cfg),
				.octet_in(octet),
				.symbol_out(LANE_SYMBOL_OUT[g])
			);
		end
	endgenerate
endmodule

// File: verif/link_props.sv
`timescale 1ns/1ps
// Port checks beside the link block
module link_props
	import link_pkg::*;
#(
	parameter int LANES = 8
) (
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic AVS_WAITREQUEST_OUT,
	input wire sample_frame_type DATA_IN,
	input wire logic DATA_VALID_IN,
	input wire logic SYNC_N_IN,
	input wire sample_frame_type PARALLEL_DATA_OUT,
	input wire logic PARALLEL_VALID_OUT,
	input wire logic PARALLEL_ENABLE_OUT,
	input wire logic [LANES-1:0][9:0] LANE_SYMBOL_OUT,
	input wire logic [LANES-1:0] LANE_ENABLE_OUT
);
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// Comma on lane 0, either disparity
	wire comma = LANE_SYMBOL_OUT[0][9:3] inside {7'h1f, 7'h60};
	// Write answered this cycle
	wire wr_done = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
	property p_answer;
		(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer timing wrong");
	property p_par_data;
		DATA_VALID_IN |=> PARALLEL_DATA_OUT == $past(DATA_IN);
	endproperty
	a_par_data: assert property (p_par_data) else $error("parallel data differs");
	property p_par_valid;
		DATA_VALID_IN && PARALLEL_ENABLE_OUT ##1 PARALLEL_ENABLE_OUT |-> PARALLEL_VALID_OUT;
	endproperty
	a_par_valid: assert property (p_par_valid) else $error("parallel valid missing");
	property p_par_src;
		PARALLEL_VALID_OUT |-> $past(DATA_VALID_IN);
	endproperty
	a_par_src: assert property (p_par_src) else $error("parallel valid without input");
	property p_par_gate;
		!PARALLEL_ENABLE_OUT |-> !PARALLEL_VALID_OUT;
	endproperty
	a_par_gate: assert property (p_par_gate) else $error("valid while parallel off");
	property p_dis_link;
		!PARALLEL_ENABLE_OUT |-> |LANE_ENABLE_OUT;
	endproperty
	a_dis_link: assert property (p_dis_link) else $error("parallel off without link");
	property p_lanes;
		LANE_ENABLE_OUT inside {8'h00, 8'h03, 8'h0f, 8'hff};
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane enable pattern wrong");
	property p_cgs;
		!SYNC_N_IN [*4] ##0 LANE_ENABLE_OUT[0] |-> comma;
	endproperty
	a_cgs: assert property (p_cgs) else $error("no comma while sync held");
	// Switching on waits one more edge for the idle phase to end
	property p_lane_chg;
		$changed(LANE_ENABLE_OUT) |-> ($rose(|LANE_ENABLE_OUT) ? $past(wr_done, 3) : $past(wr_done, 2));
	endproperty
	a_lane_chg: assert property (p_lane_chg) else $error("lanes changed without write");
	// Main scenarios reached
	c_par_off: cover property (!PARALLEL_ENABLE_OUT);
	c_all_lanes: cover property (LANE_ENABLE_OUT == 8'hff);
	c_both: cover property (PARALLEL_VALID_OUT && |LANE_ENABLE_OUT);
endmodule

// File: verif/link_rx_model.sv
`timescale 1ns/1ps
// Receiver stand-in at the far end of the lanes
module link_rx_model #(
	parameter int LANES = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [LANES-1:0][9:0] symbol_in,
	input wire logic [LANES-1:0] lane_en_in,
	input wire logic resync_in,
	input wire logic [3:0] delay_in,
	output logic sync_n_out,
	output logic sysref_out,
	output logic ila_seen_out
);
	logic [7:0] commas; // Run of commas on lane 0
	logic [5:0] tick; // Sysref timer, stops when done
	wire comma = symbol_in[0][9:3] inside {7'h1f, 7'h60};
	// Multiframe start marker of the alignment phase
	wire mf_start = symbol_in[0] inside {10'h0f4, 10'h30b};
	// Sync held low until enough commas; delay_in makes it slow
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			commas <= 8'h00;
			sync_n_out <= 1'b0;
			ila_seen_out <= 1'b0;
			tick <= 6'h00;
			sysref_out <= 1'b0;
		end else begin
			commas <= comma ? commas + {7'h00, commas != 8'hff} : 8'h00;
			if (resync_in || !lane_en_in[0]) begin
				sync_n_out <= 1'b0;
				ila_seen_out <= 1'b0;
			end else if (commas > {4'h0, delay_in} + 8'h03) begin
				sync_n_out <= 1'b1;
			end
			// Alignment seen after sync released
			if (mf_start && sync_n_out && lane_en_in[0]) begin
				ila_seen_out <= 1'b1;
			end
			// One sysref edge after reset
			tick <= tick + {5'h00, tick != 6'h3f};
			sysref_out <= tick == 6'h1f;
		end
	end
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
`include "link_cfg.svh"
// Self-checking bench for the link block
module testbench
	import link_pkg::*;
;
	logic mclk, rst_n, rd, wr, wait_rq, dvalid, pvalid, pen, sysref, sync_n, resync, ila_seen;
	logic [5:0] addr;
	logic [31:0] wdata, rdata, rv, ctl;
	logic [3:0] be, rx_delay;
	sample_frame_type din, pdata;
	logic [7:0][9:0] sym;
	logic [7:0] lane_en;
	integer fail_count, n_compared, seed;
	serial_link_tx dut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(wait_rq), .DATA_IN(din), .DATA_VALID_IN(dvalid), .SYSREF_IN(sysref),
		.SYNC_N_IN(sync_n), .PARALLEL_DATA_OUT(pdata), .PARALLEL_VALID_OUT(pvalid),
		.PARALLEL_ENABLE_OUT(pen), .LANE_SYMBOL_OUT(sym), .LANE_ENABLE_OUT(lane_en));
	link_rx_model rx (.clk_in(mclk), .rst_n_in(rst_n), .symbol_in(sym), .lane_en_in(lane_en),
		.resync_in(resync), .delay_in(rx_delay), .sync_n_out(sync_n), .sysref_out(sysref),
		.ila_seen_out(ila_seen));
	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Verdict and end of run
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Bounded wait ran out
	task automatic give_up;
		fail_count++;
		conclude();
	endtask
	// One bus cycle, held until waitrequest low
	task automatic bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		rd <= !is_wr;
		wr <= is_wr;
		do begin
			@(posedge mclk);
			n++;
		end while (wait_rq !== 1'b0 && n < 50);
		rv = rdata;
		if (wait_rq !== 1'b0) give_up();
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(what, rv & m, e);
	endtask
	// Poll link state in status
	task automatic wait_state(input logic [1:0] st);
		int n;
		n = 0;
		do begin
			bus(1'b0, 6'h0c, 32'h0);
			n++;
		end while (rv[1:0] !== st && n < 400);
		if (rv[1:0] !== st) give_up();
	endtask
	// Random words, checked one cycle later
	task automatic stream(input logic par_on);
		// Enable output is registered one edge after the control write lands
		@(posedge mclk);
		#1;
		check("parallel on", pen, par_on);
		repeat (12) begin
			@(posedge mclk);
			for (int w = 0; w < 16; w++) din.word[w] <= 16'($random(seed));
			dvalid <= 1'($random(seed));
			@(posedge mclk);
			#1;
			check("parallel valid", pvalid, dvalid & par_on);
			if (par_on && dvalid) check("parallel data", pdata, din);
		end
		@(posedge mclk);
		dvalid <= 1'b0;
	endtask
	// Lanes expected for mode and converters-per-lane code
	function automatic logic [7:0] lanes_for(input int m, input int c);
		if (m == 2) return 8'h00;
		return c == 0 ? 8'hff : (c == 1 ? 8'h0f : 8'h03);
	endfunction
	initial begin
		seed = 32'h4945;
		fail_count = 0;
		n_compared = 0;
		{rst_n, rd, wr, addr, wdata, dvalid, resync, rx_delay} = '0;
		be = 4'hf;
		din = '0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk("control reset", 6'h00, '1, `CTL_RESET);
		rd_chk("link reset", 6'h04, '1, `LNK_RESET);
		rd_chk("ident reset", 6'h08, '1, `IDN_RESET);
		bus(1'b1, 6'h20, 32'hffffffff);
		rd_chk("unmapped", 6'h20, '1, 32'h0);
		ctl = $random(seed) & 32'h0000ff0f;
		bus(1'b1, 6'h08, ctl);
		rd_chk("ident", 6'h08, '1, ctl);
		rd_chk("status idle", 6'h0c, 32'h3c, 32'h28);
		stream(1'b1);
		// Every mode and lane packing
		for (int m = 0; m < 3; m++) begin
			for (int c = 0; c < 3; c++) begin
				bus(1'b1, 6'h04, (`LNK_RESET & 32'hfffffffc) | c);
				bus(1'b1, 6'h00, 32'h1 | (m << 3));
				rd_chk("lane count", 6'h0c, 32'hf00, (32'h8 >> c) << 8);
				check("lanes", lane_en, lanes_for(m, c));
			end
		end
		// Bad packing and too narrow serialization flagged
		bus(1'b1, 6'h04, `LNK_RESET | 32'h3);
		rd_chk("cpl error", 6'h0c, 32'h10, 32'h10);
		bus(1'b1, 6'h04, 32'h0000020c);
		rd_chk("width error", 6'h0c, 32'h10, 32'h10);
		bus(1'b1, 6'h04, `LNK_RESET);
		// Each version and subclass, scrambler alternating
		for (int k = 0; k < 5; k++) begin
			rx_delay <= 4'($random(seed));
			resync <= 1'b1;
			ctl = k == 4 ? 32'h1 : 32'h21 | (k > 0) << 8 | (k > 0 ? k - 1 : 0) << 12 | (k & 1) << 2;
			// Last pass runs the link with one sample per octet pair
			bus(1'b1, 6'h04, `LNK_RESET | (k == 4) << 6);
			bus(1'b1, 6'h00, ctl);
			wait_state(2'h1);
			check("cgs", rv[1:0], 2'h1);
			resync <= 1'b0;
			wait_state(2'h3);
			check("data phase", rv[3:0], 4'hf);
			check("alignment seen", ila_seen, 1'b1);
		end
		stream(1'b1);
		bus(1'b1, 6'h00, 32'h7);
		stream(1'b0);
		bus(1'b1, 6'h00, 32'h2);
		rd_chk("link off", 6'h0c, 32'hc, 32'h8);
		check("lanes off", lane_en, 8'h00);
		stream(1'b1);
		conclude();
	end
	// Watchdog
	initial begin
		repeat (100000) @(posedge mclk);
		give_up();
	end
endmodule
bind serial_link_tx link_props #(.LANES(LANES)) u_props (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
	.AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.DATA_IN(DATA_IN), .DATA_VALID_IN(DATA_VALID_IN), .SYNC_N_IN(SYNC_N_IN),
	.PARALLEL_DATA_OUT(PARALLEL_DATA_OUT), .PARALLEL_VALID_OUT(PARALLEL_VALID_OUT),
	.PARALLEL_ENABLE_OUT(PARALLEL_ENABLE_OUT), .LANE_SYMBOL_OUT(LANE_SYMBOL_OUT),
	.LANE_ENABLE_OUT(LANE_ENABLE_OUT));
